// [verilog/temp_sensor_defs.vh]
// Register offsets, field positions, reset values and timing counts of the sensor register block
`ifndef TEMP_SENSOR_DEFS_VH
`define TEMP_SENSOR_DEFS_VH
`define ADDR_REM_SIGNED_HIGH 8'h01
`define ADDR_STATUS 8'h02
`define ADDR_GEN_CFG_A 8'h03
`define ADDR_RATE_A 8'h04
`define ADDR_GEN_CFG_B 8'h09
`define ADDR_RATE_B 8'h0a
`define ADDR_ONE_SHOT 8'h0f
`define ADDR_REM_SIGNED_LOW 8'h10
`define ADDR_OFS_HIGH 8'h11
`define ADDR_OFS_LOW 8'h12
`define ADDR_REM_UNS_HIGH 8'h31
`define ADDR_REM_UNS_LOW 8'h32
`define ADDR_DIODE_CFG 8'hbf
`define DIODE_CFG_RESET 8'h1f
`define GEN_CFG_RESET 8'h00
`define RATE_RESET 2'h2
`define OFS_RESET 8'h00
`define GEN_CFG_MASK 8'h5e
`define DIODE_CFG_WMASK 8'h7e
`define OFS_LOW_MASK 8'he0
`define DC_PIN_SEL 6
`define DC_FAULT_MASK_OT 5
`define DC_FAULT_MASK_CRIT 4
`define DC_MODEL_SEL 3
`define DC_FILT_HI 2
`define DC_FILT_LO 1
`define GC_STANDBY 6
`define GC_MASK_REM_CRIT 4
`define GC_MASK_REM_OT 3
`define GC_MASK_LOC_CRIT 2
`define GC_MASK_LOC_OT 1
`define ST_BUSY 7
`define ST_REM_OT 4
`define ST_FAULT 2
`define ST_REM_CRIT 1
`define ST_LOC 0
`define CLK_MHZ 250
`define CONT_FAULT_MS 33
`define CONT_OK_MS 63
`define RATE_1_US 364000
`define RATE_2_MS 1000
`define RATE_3_MS 2500
`endif

// [verilog/conv_timer.v]
// Conversion scheduler: paces conversions by the rate field, handles one-shot in standby
`timescale 1ns/1ns
`default_nettype none
`include "temp_sensor_defs.vh"
module conv_timer #(
	parameter integer CONT_FAULT_CYC = `CONT_FAULT_MS * 1000 * `CLK_MHZ,
	parameter integer CONT_OK_CYC = `CONT_OK_MS * 1000 * `CLK_MHZ,
	parameter integer RATE1_CYC = `RATE_1_US / 1000 * `CLK_MHZ * 1000,
	parameter integer RATE2_CYC = `RATE_2_MS * 1000 * `CLK_MHZ,
	parameter integer RATE3_CYC = `RATE_3_MS * 1000 * `CLK_MHZ
) (
	input wire clk,
	input wire rst_n,
	input wire standby,
	input wire [1:0] rate,
	input wire one_shot,
	input wire fault,
	input wire conv_done,
	output reg busy_q,
	output wire conv_start
);
	reg [31:0] cnt_q;
	reg shot_pend_q;
	wire [31:0] period;
	// Back to back runs are paced by the conversion length, which depends on the diode
	assign period = (rate == 2'h0) ? (fault ? CONT_FAULT_CYC : CONT_OK_CYC) :
		(rate == 2'h1) ? RATE1_CYC : (rate == 2'h2) ? RATE2_CYC : RATE3_CYC;
	// Periodic starts only while active; a one-shot only counts in standby
	assign conv_start = !busy_q && ((!standby && cnt_q == 32'h0) ||
		(standby && shot_pend_q));
	always @(posedge clk) begin
		if (!rst_n) begin
			cnt_q <= 32'h0;
			busy_q <= 1'b0;
			shot_pend_q <= 1'b0;
		end else begin
			if (conv_start)
				busy_q <= 1'b1;
			else if (conv_done)
				busy_q <= 1'b0;
			// A shot written mid-conversion waits; a new write wins over the consume
			if (one_shot && standby)
				shot_pend_q <= 1'b1;
			else if (conv_start || !standby)
				shot_pend_q <= 1'b0;
			if (standby || conv_start)
				cnt_q <= (period > 32'h0) ? period - 32'h1 : 32'h0;
			else if (cnt_q != 32'h0)
				cnt_q <= cnt_q - 32'h1;
		end
	end
endmodule
`default_nettype wire

// [verilog/remote_temp_sensor_regs.v]
// Register block of the two-channel temperature sensor: results, configuration, status
`timescale 1ns/1ns
`default_nettype none
`include "temp_sensor_defs.vh"
module remote_temp_sensor_regs #(
	parameter integer CONT_FAULT_CYC = `CONT_FAULT_MS * 1000 * `CLK_MHZ,
	parameter integer CONT_OK_CYC = `CONT_OK_MS * 1000 * `CLK_MHZ,
	parameter integer RATE1_CYC = `RATE_1_US / 1000 * `CLK_MHZ * 1000,
	parameter integer RATE2_CYC = `RATE_2_MS * 1000 * `CLK_MHZ,
	parameter integer RATE3_CYC = `RATE_3_MS * 1000 * `CLK_MHZ
) (
	input wire CLK,
	input wire RST_N,
	input wire [7:0] REG_ADDR,
	input wire [7:0] REG_WDATA,
	input wire REG_WR,
	input wire REG_RD,
	output reg [7:0] REG_RDATA_Q,
	input wire [12:0] REM_RAW,
	input wire REM_DONE,
	input wire FAULT_PIN,
	input wire REM_OT_PIN,
	input wire REM_CRIT_PIN,
	input wire LOC_PIN,
	input wire ADDR_SEL_PIN,
	output wire CONV_START,
	output wire CONV_BUSY,
	output wire MODEL_PROC,
	output wire FILTER_ON,
	output wire STANDBY,
	output wire OVERTEMP_SHUTDOWN_OUT,
	output wire OVERTEMP_SHUTDOWN_OE,
	output wire CRITICAL_OUT_N,
	output wire ADDRESS_SELECT_IN
);
	reg [7:0] diode_cfg_q;
	reg [7:0] gen_cfg_q;
	reg [1:0] rate_q;
	reg [7:0] ofs_hi_q;
	reg [7:0] ofs_lo_q;
	reg [12:0] result_q;
	reg [7:0] lsb_lock_q;
	reg lock_q;
	reg [4:0] pin_s1_q;
	reg [4:0] pin_s2_q;
	reg [7:0] rdata_d;
	reg [7:0] uns_lo_live;
	wire fault;
	wire rem_ot;
	wire rem_crit;
	wire loc_flag;
	wire [13:0] sum;
	wire [12:0] sum_sat;
	wire filt_on;
	wire one_shot;
	wire [7:0] uns_hi;
	wire [7:0] status;
	wire ot_any;
	wire crit_any;
	// Two flops on every pin-side level before anything looks at it
	always @(posedge CLK) begin
		if (!RST_N) begin
			pin_s1_q <= 5'h00;
			pin_s2_q <= 5'h00;
		end else begin
			pin_s1_q <= {ADDR_SEL_PIN, LOC_PIN, REM_CRIT_PIN, REM_OT_PIN, FAULT_PIN};
			pin_s2_q <= pin_s1_q;
		end
	end
	assign fault = pin_s2_q[0];
	assign rem_ot = pin_s2_q[1];
	assign rem_crit = pin_s2_q[2];
	assign loc_flag = pin_s2_q[3];
	assign ADDRESS_SELECT_IN = diode_cfg_q[`DC_PIN_SEL] ? 1'b0 : pin_s2_q[4];

	// Offset: sign-extend 8.3 offset to 5 fraction bits and add, clamping to 0..255.96875
	wire [13:0] ofs_ext;
	assign ofs_ext = {ofs_hi_q[7], ofs_hi_q, ofs_lo_q[7:5], 2'b00};
	assign sum = {1'b0, REM_RAW} + ofs_ext;
	// The raw code is unsigned: bit 13 set means underflow for a negative offset
	// and overflow for a positive one, so the offset sign picks the clamp
	assign sum_sat = ofs_hi_q[7] ? (sum[13] ? 13'h0000 : sum[12:0]) :
		(sum[13] ? 13'h1fff : sum[12:0]);
	assign filt_on = diode_cfg_q[`DC_FILT_HI] & diode_cfg_q[`DC_FILT_LO];
	assign FILTER_ON = filt_on;
	assign MODEL_PROC = diode_cfg_q[`DC_MODEL_SEL];
	assign STANDBY = gen_cfg_q[`GC_STANDBY];

	// Fault forces the unsigned result to zero degrees
	assign uns_hi = fault ? 8'h00 : result_q[12:5];
	always @* begin
		uns_lo_live = 8'h00;
		if (!fault) begin
			if (filt_on)
				uns_lo_live = {result_q[4:0], 3'b000};
			else
				uns_lo_live = {result_q[4:2], 5'b00000};
		end
	end

	// Unmasked events drive the open-drain limit outputs; a masked fault is kept off them
	assign ot_any = (rem_ot & ~gen_cfg_q[`GC_MASK_REM_OT]) |
		(loc_flag & ~gen_cfg_q[`GC_MASK_LOC_OT]) |
		(fault & ~diode_cfg_q[`DC_FAULT_MASK_OT]);
	assign crit_any = (rem_crit & ~gen_cfg_q[`GC_MASK_REM_CRIT]) |
		(loc_flag & ~gen_cfg_q[`GC_MASK_LOC_CRIT]) |
		(fault & ~diode_cfg_q[`DC_FAULT_MASK_CRIT]);
	assign OVERTEMP_SHUTDOWN_OUT = 1'b0;
	assign OVERTEMP_SHUTDOWN_OE = diode_cfg_q[`DC_PIN_SEL] & ot_any;
	assign CRITICAL_OUT_N = ~crit_any;

	assign status = {CONV_BUSY, 2'b00, rem_ot, 1'b0, fault, rem_crit, loc_flag};
	assign one_shot = REG_WR && (REG_ADDR == `ADDR_ONE_SHOT);

	conv_timer #(
		.CONT_FAULT_CYC(CONT_FAULT_CYC),
		.CONT_OK_CYC(CONT_OK_CYC),
		.RATE1_CYC(RATE1_CYC),
		.RATE2_CYC(RATE2_CYC),
		.RATE3_CYC(RATE3_CYC)
	) u_timer (
		.clk(CLK),
		.rst_n(RST_N),
		.standby(gen_cfg_q[`GC_STANDBY]),
		.rate(rate_q),
		.one_shot(one_shot),
		.fault(fault),
		.conv_done(REM_DONE),
		.busy_q(CONV_BUSY),
		.conv_start(CONV_START)
	);

	// Register writes; reserved bits are stored as their fixed read values
	always @(posedge CLK) begin
		if (!RST_N) begin
			diode_cfg_q <= `DIODE_CFG_RESET;
			gen_cfg_q <= `GEN_CFG_RESET;
			rate_q <= `RATE_RESET;
			ofs_hi_q <= `OFS_RESET;
			ofs_lo_q <= `OFS_RESET;
		end else if (REG_WR) begin
			case (REG_ADDR)
				`ADDR_DIODE_CFG: diode_cfg_q <= (REG_WDATA & `DIODE_CFG_WMASK) | 8'h01;
				`ADDR_GEN_CFG_A, `ADDR_GEN_CFG_B: gen_cfg_q <= REG_WDATA & `GEN_CFG_MASK;
				`ADDR_RATE_A, `ADDR_RATE_B: rate_q <= REG_WDATA[1:0];
				`ADDR_OFS_HIGH: ofs_hi_q <= REG_WDATA;
				`ADDR_OFS_LOW: ofs_lo_q <= REG_WDATA & `OFS_LOW_MASK;
				default: ;
			endcase
		end
	end

	// Result capture at conversion end; the low-byte lock holds its own copy
	always @(posedge CLK) begin
		if (!RST_N) begin
			result_q <= 13'h0000;
			lsb_lock_q <= 8'h00;
			lock_q <= 1'b0;
		end else begin
			if (REM_DONE)
				result_q <= sum_sat;
			// High read relocks every time, even while already locked
			if (REG_RD && REG_ADDR == `ADDR_REM_UNS_HIGH) begin
				lsb_lock_q <= uns_lo_live;
				lock_q <= 1'b1;
			end else if (REG_RD && REG_ADDR == `ADDR_REM_UNS_LOW) begin
				lock_q <= 1'b0;
			end
		end
	end

	// Read mux; unmapped and write-only addresses read zero
	always @* begin
		case (REG_ADDR)
			`ADDR_STATUS: rdata_d = status;
			`ADDR_GEN_CFG_A, `ADDR_GEN_CFG_B: rdata_d = gen_cfg_q;
			`ADDR_RATE_A, `ADDR_RATE_B: rdata_d = {6'h00, rate_q};
			`ADDR_OFS_HIGH: rdata_d = ofs_hi_q;
			`ADDR_OFS_LOW: rdata_d = ofs_lo_q;
			`ADDR_REM_UNS_HIGH: rdata_d = uns_hi;
			`ADDR_REM_UNS_LOW: rdata_d = lock_q ? lsb_lock_q : uns_lo_live;
			`ADDR_REM_SIGNED_HIGH: rdata_d = fault ? 8'h80 : 8'h00;
			`ADDR_DIODE_CFG: rdata_d = diode_cfg_q;
			default: rdata_d = 8'h00;
		endcase
	end

	always @(posedge CLK) begin
		if (!RST_N)
			REG_RDATA_Q <= 8'h00;
		else if (REG_RD)
			REG_RDATA_Q <= rdata_d;
	end
endmodule
`default_nettype wire

// [verif/remote_temp_sensor_regs_sva.sv]
// Port-level assertions for the sensor register block
`timescale 1ns/1ns
`default_nettype none
module temp_regs_chk (
	input wire CLK,
	input wire RST_N,
	input wire [7:0] REG_ADDR,
	input wire [7:0] REG_WDATA,
	input wire REG_WR,
	input wire REG_RD,
	input wire [7:0] REG_RDATA_Q,
	input wire REM_DONE,
	input wire CONV_START,
	input wire CONV_BUSY,
	input wire STANDBY,
	input wire FILTER_ON,
	input wire MODEL_PROC
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	// Write to the diode configuration location
	wire wcfg = REG_WR && REG_ADDR == 8'hbf;
	standby_set_a: assert property (REG_WR && (REG_ADDR == 8'h03 || REG_ADDR == 8'h09)
		|=> STANDBY == $past(REG_WDATA[6])) else $error("standby bit not taken");
	filter_sel_a: assert property (wcfg
		|=> FILTER_ON == ($past(REG_WDATA[2:1]) == 2'b11)) else $error("filter select wrong");
	model_sel_a: assert property (wcfg
		|=> MODEL_PROC == $past(REG_WDATA[3])) else $error("model select wrong");
	oneshot_go_a: assert property (REG_WR && REG_ADDR == 8'h0f && STANDBY && !CONV_BUSY
		|=> CONV_START) else $error("one-shot did not start");
	standby_quiet_a: assert property (STANDBY && CONV_START
		|-> $past(REG_WR) && $past(REG_ADDR) == 8'h0f) else $error("start in standby");
	busy_span_a: assert property (CONV_START |=> CONV_BUSY) else $error("busy missing");
	busy_end_a: assert property (REM_DONE && STANDBY
		|-> ##2 !CONV_BUSY) else $error("busy stuck after done");
	rate_rsvd_a: assert property (REG_RD && (REG_ADDR == 8'h04 || REG_ADDR == 8'h0a)
		|=> REG_RDATA_Q[7:2] == 6'h00) else $error("rate upper bits set");
	diode_rsvd_a: assert property (REG_RD && REG_ADDR == 8'hbf
		|=> !REG_RDATA_Q[7] && REG_RDATA_Q[0]) else $error("diode reserved bits wrong");
	// Main traffic kinds
	cover property (STANDBY && CONV_START);
	cover property (REG_RD && REG_ADDR == 8'h32);
	cover property (REM_DONE && !STANDBY);
endmodule
bind remote_temp_sensor_regs temp_regs_chk temp_regs_chk_inst (.CLK, .RST_N, .REG_ADDR,
	.REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA_Q, .REM_DONE, .CONV_START, .CONV_BUSY, .STANDBY,
	.FILTER_ON, .MODEL_PROC);
`default_nettype wire

// [verif/reg_host_model.sv]
// Register host model issuing single-cycle read and write strobes
`timescale 1ns/1ns
`default_nettype none
module reg_host (
	input wire logic clk,
	input wire logic [7:0] rdata,
	output var logic [7:0] addr = 8'h00,
	output var logic [7:0] wdata = 8'h00,
	output var logic wr_en = 1'b0,
	output var logic rd_en = 1'b0
);
	// Strobe stays up until the edge that takes it, then drops
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask
	// Data is registered on the strobe edge and sampled 1 ns later
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 d = rdata;
	endtask
endmodule
`default_nettype wire

// [verif/remote_temp_sensor_regs_test.sv]
// Self-checking bench for the sensor register block
`timescale 1ns/1ns
`default_nettype none
module remote_temp_sensor_regs_test;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic rem_done = 1'b0;
	logic [12:0] raw = 13'h0000;
	logic [4:0] pins = 5'h00;
	logic [2:0] fe_q = 3'h0;
	logic [7:0] addr, wdata, rdata, d;
	logic wr_en, rd_en, start, busy, model, filt, stby, asel;
	logic od, oe, crit_n;
	int err_total = 0;
	int comparisons = 0;
	int cyc = 0;
	int gap;
	always #2 clk = ~clk;
	remote_temp_sensor_regs #(.CONT_FAULT_CYC(20), .CONT_OK_CYC(40), .RATE1_CYC(60),
		.RATE2_CYC(80), .RATE3_CYC(100)) remote_temp_sensor_regs_inst (.CLK(clk), .RST_N(rst_n),
		.REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr_en), .REG_RD(rd_en), .REG_RDATA_Q(rdata),
		.REM_RAW(raw), .REM_DONE(rem_done), .FAULT_PIN(pins[0]), .REM_OT_PIN(pins[1]),
		.REM_CRIT_PIN(pins[2]), .LOC_PIN(pins[3]), .ADDR_SEL_PIN(pins[4]), .CONV_START(start),
		.CONV_BUSY(busy), .MODEL_PROC(model), .FILTER_ON(filt), .STANDBY(stby),
		.OVERTEMP_SHUTDOWN_OUT(od), .OVERTEMP_SHUTDOWN_OE(oe), .CRITICAL_OUT_N(crit_n),
		.ADDRESS_SELECT_IN(asel));
	reg_host reg_host_inst (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata),
		.wr_en(wr_en), .rd_en(rd_en));
	// Front end finishes each conversion six cycles after launch
	always @(posedge clk) begin
		if (start)
			fe_q <= 3'h6;
		else if (fe_q != 3'h0)
			fe_q <= fe_q - 3'h1;
		rem_done <= (fe_q == 3'h1);
	end
	// Hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			stop_test();
		end
	end
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		reg_host_inst.wr(a, v);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		reg_host_inst.rd(a, d);
		chk($sformatf("reg %h", a), d, exp);
	endtask
	// Polled on the edge so a pending start is never overtaken
	task automatic idle();
		repeat (2) @(posedge clk);
		for (int i = 0; i < 40 && busy; i++) @(posedge clk);
	endtask
	task automatic shot(input logic [12:0] r);
		idle();
		raw <= r;
		wr(8'h0f, 8'h00);
		#1 chk("start", start, 8'h01);
		idle();
	endtask
	task automatic t_cfg();
		rchk(8'h03, 8'h00);
		rchk(8'h0a, 8'h02);
		rchk(8'hbf, 8'h1f);
		rchk(8'h55, 8'h00);
		pins <= 5'h10;
		wr(8'hbf, 8'hff);
		rchk(8'hbf, 8'h7f);
		chk("filter", filt, 8'h01);
		chk("model", model, 8'h01);
		chk("addr pin", asel, 8'h00);
		wr(8'hbf, 8'h02);
		rchk(8'hbf, 8'h03);
		chk("filter", filt, 8'h00);
		chk("addr pin", asel, 8'h01);
		wr(8'h09, 8'hff);
		rchk(8'h03, 8'h5e);
		chk("standby", stby, 8'h01);
		wr(8'h04, 8'hff);
		rchk(8'h0a, 8'h03);
		wr(8'h12, 8'hff);
		rchk(8'h12, 8'he0);
		wr(8'h12, 8'h00);
	endtask
	task automatic t_lock();
		wr(8'hbf, 8'h07);
		shot({8'h64, 5'h15});
		rchk(8'h31, 8'h64);
		shot({8'h65, 5'h03});
		rchk(8'h32, 8'ha8);
		rchk(8'h32, 8'h18);
		rchk(8'h31, 8'h65);
		shot({8'h70, 5'h1f});
		rchk(8'h31, 8'h70);
		shot({8'h71, 5'h00});
		rchk(8'h32, 8'hf8);
		wr(8'hbf, 8'h01);
		wr(8'h11, 8'h02);
		wr(8'h12, 8'h20);
		shot({8'h64, 5'h17});
		rchk(8'h31, 8'h66);
		rchk(8'h32, 8'hc0);
		wr(8'h11, 8'hfe);
		wr(8'h12, 8'h00);
		shot({8'h64, 5'h17});
		rchk(8'h31, 8'h62);
	endtask
	task automatic t_status();
		pins <= 5'h0f;
		repeat (3) @(posedge clk);
		rchk(8'h02, 8'h17);
		wr(8'h0f, 8'h00);
		rchk(8'h02, 8'h97);
		shot(13'h0c80);
		rchk(8'h31, 8'h00);
		// Shared pin as shutdown output with fault masks off, then with both masks on
		wr(8'hbf, 8'h41);
		#1 chk("os oe", oe, 8'h01);
		chk("os data", od, 8'h00);
		chk("crit out", crit_n, 8'h00);
		wr(8'hbf, 8'h71);
		#1 chk("os oe", oe, 8'h00);
		chk("crit out", crit_n, 8'h01);
	endtask
	// Start-to-start spacing for every rate code, last one with a faulty diode
	task automatic t_rate();
		int per[5] = '{40, 60, 80, 100, 20};
		wr(8'h03, 8'h00);
		for (int k = 0; k < 5; k++) begin
			wr(8'h04, 8'(k % 4));
			pins <= {4'h0, k == 4};
			for (int j = 0; j < 2; j++) begin
				gap = 0;
				do begin
					@(posedge clk);
					#1 gap++;
				end while (!start && gap < 300);
			end
			chk("period", 8'(gap), 8'(per[k]));
		end
	endtask
	task automatic stop_test();
		$display("comparisons %0d errors %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		t_cfg();
		t_lock();
		t_status();
		t_rate();
		stop_test();
	end
endmodule
`default_nettype wire
